// *** common/wws_defs.svh ***
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH
// -------------------------------------------------------------
// timing figures
// -------------------------------------------------------------
`define WWS_CLK_HZ          20000000
`define WWS_OPEN_US         18000
`define WWS_RELEASE_US      220000
`define WWS_DETECT_US       30
`define WWS_OPEN_CYC        ((`WWS_OPEN_US * (`WWS_CLK_HZ / 1000000)))
`define WWS_RELEASE_CYC     ((`WWS_RELEASE_US * (`WWS_CLK_HZ / 1000000)))
`define WWS_DETECT_CYC      ((`WWS_DETECT_US * (`WWS_CLK_HZ / 1000000)))
// -------------------------------------------------------------
// window ratios, times 40: open 40, closed 10, reset 20, long 160
// -------------------------------------------------------------
`define WWS_RATIO_BASE      40
`define WWS_RATIO_OPEN      40
`define WWS_RATIO_CLOSED    10
`define WWS_RATIO_RESET     20
`define WWS_RATIO_LONG      160
`define WWS_CNT_W           32
`endif

// *** common/wws_pkg.sv ***
package wws_pkg;
  typedef enum logic [2:0] {
    WWS_OFF     = 3'b000,
    WWS_IGNORE  = 3'b001,
    WWS_LONG    = 3'b010,
    WWS_OPEN    = 3'b011,
    WWS_CLOSED  = 3'b100,
    WWS_RESET   = 3'b101
  } wws_state_t;
endpackage : wws_pkg

// *** common/wws_kick_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface wws_kick_if;
  logic kick_pulse;
  modport src (output kick_pulse);
  modport dst (input  kick_pulse);
endinterface : wws_kick_if
`default_nettype wire

// *** logic/wws_kick_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module wws_kick_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic kick_pin,
  wws_kick_if.src   kick
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic pulse_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      prev_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      meta_reg  <= kick_pin;
      sync_reg  <= meta_reg;
      prev_reg  <= sync_reg;
      pulse_reg <= sync_reg & ~prev_reg;
    end
  end
  assign kick.kick_pulse = pulse_reg;
endmodule : wws_kick_sync
`default_nettype wire

// *** logic/wws_top.sv ***
// Notes on behaviour
// - after supply good, hold reset low for release delay, then start supervising.
// - five supervision states; first open window after ignoring is long.
// - supervision starts in ignoring; kicks are disregarded there.
// - ignoring expiry enters long open window, four times normal length.
// - kick during open or long window enters closed window, ramp restarts.
// - kick in closed window is too early; reset state drives reset low.
// - reset expiry releases reset, restarts ramp, enters ignoring.
// - closed window expiry without kick enters open window.
// - open window expiry without kick is too late; enter reset.
// - separate-output variant drives detector output low in reset state.
// - inhibit low stops supervision; fault output high, timing node low.
// - shared-pin variant: inhibit low leaves outputs to detector alone.
// - inhibit rising restarts supervision in ignoring state.
// - reset held low until release timer reaches threshold, then high.
// - undervoltage asserts reset after fixed detection delay.
// - windows scale from open time: closed quarter, reset half, long four.
// - chip enable low means standby; supervision and monitoring stop.
// - standby holds reset or detector low, fault output released high.
// - inhibit defaults high when the pin is left open.
`timescale 1ns/100ps
`default_nettype none
`include "wws_defs.svh"
module wws_top #(
  parameter bit          SEPARATE_OUT = 1'b0,
  parameter int unsigned OPEN_CYC     = `WWS_OPEN_CYC,
  parameter int unsigned RELEASE_CYC  = `WWS_RELEASE_CYC,
  parameter int unsigned DETECT_CYC   = `WWS_DETECT_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic supply_good,
  input  wire logic chip_enable,
  input  wire logic monitor_hold_n,
  input  wire logic kick_pin,
  output var  logic reset_out_n,
  output var  logic fault_out_n,
  output var  logic ramp_active,
  output var  logic shared_timing_node,
  output var  logic window_timing_node,
  output var  wws_pkg::wws_state_t wd_state
);
  import wws_pkg::*;

  if (OPEN_CYC < 4 || RELEASE_CYC < 1 || DETECT_CYC < 1) begin : g_bad_cfg
    $error("wws_top: timing counts too small");
  end

  // -------------------------------------------------------------
  // terminal counts
  // -------------------------------------------------------------
  localparam logic [`WWS_CNT_W-1:0] T_OPEN =
    `WWS_CNT_W'(OPEN_CYC * `WWS_RATIO_OPEN / `WWS_RATIO_BASE - 1);
  localparam logic [`WWS_CNT_W-1:0] T_CLOSED =
    `WWS_CNT_W'(OPEN_CYC * `WWS_RATIO_CLOSED / `WWS_RATIO_BASE - 1);
  localparam logic [`WWS_CNT_W-1:0] T_RESET =
    `WWS_CNT_W'(OPEN_CYC * `WWS_RATIO_RESET / `WWS_RATIO_BASE - 1);
  localparam logic [`WWS_CNT_W-1:0] T_LONG =
    `WWS_CNT_W'(OPEN_CYC * `WWS_RATIO_LONG / `WWS_RATIO_BASE - 1);
  localparam logic [`WWS_CNT_W-1:0] T_RELEASE =
    `WWS_CNT_W'(RELEASE_CYC - 1);
  localparam logic [`WWS_CNT_W-1:0] T_DETECT =
    `WWS_CNT_W'(DETECT_CYC - 1);

  function automatic logic [`WWS_CNT_W-1:0] term_of(wws_state_t s);
    case (s)
      WWS_IGNORE: term_of = T_OPEN;
      WWS_LONG:   term_of = T_LONG;
      WWS_OPEN:   term_of = T_OPEN;
      WWS_CLOSED: term_of = T_CLOSED;
      WWS_RESET:  term_of = T_RESET;
      default:    term_of = T_OPEN;
    endcase
  endfunction : term_of

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       good_s;
  logic       ce_s;
  logic       hold_n_s;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_reg <= 3'h6;
      pin_sync_reg <= 3'h6;
    end else begin
      pin_meta_reg <= {monitor_hold_n, chip_enable, supply_good};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign good_s   = pin_sync_reg[0];
  assign ce_s     = pin_sync_reg[1];
  assign hold_n_s = pin_sync_reg[2];

  wws_kick_if kick ();
  wws_kick_sync u_kick (
    .clk      (clk),
    .srst     (srst),
    .kick_pin (kick_pin),
    .kick     (kick.src)
  );

  // -------------------------------------------------------------
  // voltage detector: release and detection delays
  // -------------------------------------------------------------
  logic                  det_ok_reg;
  logic [`WWS_CNT_W-1:0] det_cnt_reg;
  always_ff @(posedge clk) begin
    if (srst || !ce_s) begin
      det_ok_reg  <= 1'b0;
      det_cnt_reg <= '0;
    end else if (!det_ok_reg) begin
      if (!good_s) begin
        det_cnt_reg <= '0;
      end else if (det_cnt_reg == T_RELEASE) begin
        det_ok_reg  <= 1'b1;
        det_cnt_reg <= '0;
      end else begin
        det_cnt_reg <= det_cnt_reg + 1'b1;
      end
    end else begin
      if (good_s) begin
        det_cnt_reg <= '0;
      end else if (det_cnt_reg == T_DETECT) begin
        det_ok_reg  <= 1'b0;
        det_cnt_reg <= '0;
      end else begin
        det_cnt_reg <= det_cnt_reg + 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // watchdog state machine
  // -------------------------------------------------------------
  wws_state_t            state_reg;
  wws_state_t            state_next;
  logic [`WWS_CNT_W-1:0] ramp_reg;
  logic                  expired;
  logic                  run;
  assign run     = ce_s && det_ok_reg && hold_n_s;
  assign expired = (ramp_reg == term_of(state_reg));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WWS_OFF: begin
        state_next = WWS_IGNORE;
      end
      WWS_IGNORE: begin
        if (expired) begin
          state_next = WWS_LONG;
        end
      end
      WWS_LONG, WWS_OPEN: begin
        if (kick.kick_pulse) begin
          state_next = WWS_CLOSED;
        end else if (expired) begin
          state_next = WWS_RESET;
        end
      end
      WWS_CLOSED: begin
        if (kick.kick_pulse) begin
          state_next = WWS_RESET;
        end else if (expired) begin
          state_next = WWS_OPEN;
        end
      end
      WWS_RESET: begin
        if (expired) begin
          state_next = WWS_IGNORE;
        end
      end
      default: begin
        state_next = WWS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      state_reg <= WWS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !run || state_next != state_reg) begin
      ramp_reg <= '0;
    end else begin
      ramp_reg <= ramp_reg + 1'b1;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  logic wd_reset;
  assign wd_reset = (state_next == WWS_RESET) && run;
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_out_n        <= 1'b0;
      fault_out_n        <= 1'b1;
      ramp_active        <= 1'b0;
      shared_timing_node <= 1'b0;
      window_timing_node <= 1'b0;
      wd_state           <= WWS_OFF;
    end else begin
      wd_state    <= run ? state_next : WWS_OFF;
      ramp_active <= run && state_next != WWS_OFF;
      if (SEPARATE_OUT) begin
        reset_out_n        <= ce_s && det_ok_reg && !wd_reset;
        fault_out_n        <= !wd_reset;
        window_timing_node <= run && state_next != WWS_OFF;
        shared_timing_node <= ce_s && !det_ok_reg && good_s;
      end else begin
        reset_out_n        <= ce_s && det_ok_reg && !wd_reset;
        fault_out_n        <= 1'b1;
        window_timing_node <= 1'b0;
        shared_timing_node <= (ce_s && !det_ok_reg && good_s) ||
                              (run && state_next != WWS_OFF);
      end
    end
  end
endmodule : wws_top
`default_nettype wire

// *** tb/wws_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// window checks
// ----
module wws_chk #(
  parameter int unsigned OPEN_CYC = 40
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                chip_enable,
  input wire logic                reset_out_n,
  input wire logic                fault_out_n,
  input wire logic                window_timing_node,
  input wire wws_pkg::wws_state_t wd_state
);
  import wws_pkg::*;
  wws_state_t  p_reg;
  int unsigned d_reg;
  always_ff @(posedge clk) begin
    p_reg <= wd_state;
    d_reg <= (wd_state != p_reg) ? 1 : d_reg + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  rst_low_a: assert property (wd_state == WWS_RESET |->
    !reset_out_n && !fault_out_n) else $error("reset out high");
  ign_len_a: assert property (wd_state == WWS_LONG &&
    p_reg == WWS_IGNORE |-> d_reg == OPEN_CYC) else $error("ignore len");
  long_len_a: assert property (wd_state == WWS_RESET &&
    p_reg == WWS_LONG |-> d_reg == 4 * OPEN_CYC) else $error("long len");
  open_len_a: assert property (wd_state == WWS_RESET &&
    p_reg == WWS_OPEN |-> d_reg == OPEN_CYC) else $error("open len");
  cls_len_a: assert property (wd_state == WWS_OPEN &&
    p_reg == WWS_CLOSED |-> d_reg == OPEN_CYC / 4) else $error("closed len");
  rst_len_a: assert property (wd_state == WWS_IGNORE &&
    p_reg == WWS_RESET |-> d_reg == OPEN_CYC / 2) else $error("reset len");
  open_exit_a: assert property (p_reg inside {WWS_OPEN, WWS_LONG} &&
    wd_state != p_reg |-> wd_state inside {WWS_CLOSED, WWS_RESET, WWS_OFF})
    else $error("open exit");
  stby_a: assert property (!chip_enable [*5] |=>
    !reset_out_n && fault_out_n && wd_state == WWS_OFF) else $error("stby");
  off_out_a: assert property (wd_state == WWS_OFF &&
    p_reg == WWS_OFF |-> fault_out_n && !window_timing_node)
    else $error("off outputs");
  cv_cls: cover property (p_reg == WWS_CLOSED && wd_state == WWS_OPEN);
  cv_early: cover property (p_reg == WWS_CLOSED && wd_state == WWS_RESET);
  cv_late: cover property (p_reg == WWS_LONG && wd_state == WWS_RESET);
endmodule : wws_chk
`default_nettype wire

// *** tb/wws_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// host kick source
// ----
module wws_host (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] gap,
  output var  logic       kick_pin = 1'b0
);
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge clk) begin
    cnt_reg  <= (!run || cnt_reg >= gap - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
    kick_pin <= run && cnt_reg < 8'h02;
  end
endmodule : wws_host
`default_nettype wire

// *** tb/tb_window_watchdog_supervisor.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// bench
// ----
module tb_window_watchdog_supervisor;
  import wws_pkg::*;
  localparam int unsigned OC = 40;
  logic       clk, srst, supply_good, chip_enable, monitor_hold_n, run;
  logic       kick_pin, reset_out_n, fault_out_n, ramp_active;
  logic       shared_timing_node, window_timing_node;
  logic [7:0] gap;
  wws_state_t wd_state;
  int         err_total, total_checks, waited, i;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  wws_top #(.SEPARATE_OUT(1'b1), .OPEN_CYC(OC), .RELEASE_CYC(20),
    .DETECT_CYC(3)) wws_top_inst (.clk, .srst, .supply_good, .chip_enable,
    .monitor_hold_n, .kick_pin, .reset_out_n, .fault_out_n, .ramp_active,
    .shared_timing_node, .window_timing_node, .wd_state);
  wws_host wws_host_inst (.clk, .run, .gap, .kick_pin);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task wait_st(input wws_state_t s, input int n);
    for (waited = 0; waited < n && wd_state !== s; waited++) @(negedge clk);
    if (wd_state !== s) begin
      err_total++;
      $display("unexpected at %0t: no state %0d", $time, s);
      stop_test;
    end
  endtask : wait_st
  task t_early;
    @(posedge clk) run <= 1'b1;
    gap <= 8'h06;
    wait_st(WWS_LONG, OC + 8);
    wait_st(WWS_CLOSED, 12);
    wait_st(WWS_RESET, 12);
    chk(reset_out_n, 1'b0);
    chk(fault_out_n, 1'b0);
    @(posedge clk) run <= 1'b0;
    wait_st(WWS_IGNORE, OC / 2 + 4);
    chk(reset_out_n, 1'b1);
    $display("test early done");
  endtask : t_early
  task t_window;
    @(posedge clk) run <= 1'b1;
    gap <= 8'h19;
    wait_st(WWS_CLOSED, 5 * OC + 40);
    wait_st(WWS_OPEN, OC / 4 + 2);
    waited = 0;
    for (i = 0; i < 150; i++) begin
      @(negedge clk);
      if (wd_state === WWS_RESET) waited = -1;
    end
    chk(waited, 0);
    @(posedge clk) run <= 1'b0;
    wait_st(WWS_RESET, OC + OC / 4 + 8);
    chk(reset_out_n, 1'b0);
    $display("test window done");
  endtask : t_window
  task t_late;
    wait_st(WWS_LONG, OC + OC / 2 + 8);
    wait_st(WWS_RESET, 4 * OC + 8);
    chk(waited >= 4 * OC - 2, 1'b1);
    $display("test late done");
  endtask : t_late
  task t_inhibit;
    @(posedge clk) monitor_hold_n <= 1'b0;
    run <= 1'b1;
    gap <= 8'h06;
    wait_st(WWS_OFF, 8);
    repeat (60) @(negedge clk);
    chk(wd_state, WWS_OFF);
    chk(reset_out_n, 1'b1);
    chk(fault_out_n, 1'b1);
    chk(window_timing_node, 1'b0);
    chk(ramp_active, 1'b0);
    @(posedge clk) monitor_hold_n <= 1'b1;
    run <= 1'b0;
    wait_st(WWS_IGNORE, 8);
    chk(wd_state, WWS_IGNORE);
    chk(ramp_active, 1'b1);
    $display("test inhibit done");
  endtask : t_inhibit
  task t_standby;
    @(posedge clk) chip_enable <= 1'b0;
    repeat (8) @(negedge clk);
    chk(reset_out_n, 1'b0);
    chk(fault_out_n, 1'b1);
    @(posedge clk) chip_enable <= 1'b1;
    repeat (10) @(negedge clk);
    chk(shared_timing_node, 1'b1);
    wait_st(WWS_IGNORE, 40);
    chk(shared_timing_node, 1'b0);
    @(posedge clk) supply_good <= 1'b0;
    @(posedge clk) supply_good <= 1'b1;
    repeat (10) @(negedge clk);
    chk(reset_out_n, 1'b1);
    @(posedge clk) supply_good <= 1'b0;
    for (i = 0; i < 20 && reset_out_n !== 1'b0; i++) @(negedge clk);
    chk(i >= 3 && i <= 9, 1'b1);
    $display("test standby done");
  endtask : t_standby
  initial begin
    srst = 1'b1;
    supply_good = 1'b0;
    chip_enable = 1'b1;
    monitor_hold_n = 1'b1;
    run = 1'b0;
    gap = 8'h19;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    supply_good <= 1'b1;
    wait_st(WWS_IGNORE, 40);
    chk(waited >= 20 && waited <= 30, 1'b1);
    chk(reset_out_n, 1'b1);
    t_early;
    t_window;
    t_late;
    t_inhibit;
    t_standby;
    stop_test;
  end
endmodule : tb_window_watchdog_supervisor
bind wws_top wws_chk #(.OPEN_CYC(OPEN_CYC)) wws_chk_inst (.clk(clk),
  .srst(srst), .chip_enable(chip_enable), .reset_out_n(reset_out_n),
  .fault_out_n(fault_out_n), .window_timing_node(window_timing_node),
  .wd_state(wd_state));
`default_nettype wire
